// file: rtl/io_ports.sv
// Four 8-bit port latches with output stages and pin read paths
`timescale 1ns/10ps
module io_ports (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [3:0] cycle_state_i,
	input wire io_ports_pkg::core_write_s core_write_i,
	input wire logic [1:0] read_port_sel_i,
	input wire logic external_access_select_i,
	input wire io_ports_pkg::ext_bus_s ext_bus_i,
	input wire io_ports_pkg::byte_t open_drain_port_pin_i,
	input wire io_ports_pkg::byte_t port_one_pin_i,
	input wire io_ports_pkg::byte_t port_two_pin_i,
	input wire io_ports_pkg::byte_t port_three_pin_i,
	output io_ports_pkg::byte_t latch_read_o,
	output io_ports_pkg::byte_t pin_read_o,
	output io_ports_pkg::pin_drive_s open_drain_port_o,
	output io_ports_pkg::pin_drive_s port_one_o,
	output io_ports_pkg::pin_drive_s port_two_o,
	output io_ports_pkg::pin_drive_s port_three_o
);
	////////////////////////////////////////////////////////////////////////////////
	// Latches
	io_ports_pkg::byte_t latch_reg [io_ports_pkg::NUM_PORTS];
	io_ports_pkg::byte_t latch_next [io_ports_pkg::NUM_PORTS];
	io_ports_pkg::byte_t stage_reg [io_ports_pkg::NUM_PORTS];
	io_ports_pkg::byte_t stage_next [io_ports_pkg::NUM_PORTS];
	io_ports_pkg::byte_t sample_reg [io_ports_pkg::NUM_PORTS];
	io_ports_pkg::byte_t sample_next [io_ports_pkg::NUM_PORTS];
	io_ports_pkg::byte_t pin_synced [io_ports_pkg::NUM_PORTS];
	io_ports_pkg::byte_t pin_raw [io_ports_pkg::NUM_PORTS];
	io_ports_pkg::byte_t latch_read_reg, latch_read_next;
	io_ports_pkg::byte_t pin_read_reg, pin_read_next;
	io_ports_pkg::pin_drive_s drive_reg [io_ports_pkg::NUM_PORTS];
	io_ports_pkg::pin_drive_s drive_next [io_ports_pkg::NUM_PORTS];
	logic ext_bus_active;

	////////////////////////////////////////////////////////////////////////////////
	// Decode helpers
	function automatic logic is_sample_state(input int idx, input logic [3:0] st);
		if (idx == io_ports_pkg::OPEN_DRAIN_IDX || idx == io_ports_pkg::PORT_ONE_IDX) begin
			is_sample_state = (st == io_ports_pkg::STATE_NINE);
		end else begin
			is_sample_state = (st == io_ports_pkg::STATE_TEN);
		end
	endfunction : is_sample_state

	// Port select shared by the latch and pin read paths
	function automatic io_ports_pkg::byte_t pick_port(
		input io_ports_pkg::byte_t src [io_ports_pkg::NUM_PORTS],
		input logic [1:0] sel
	);
		unique case (sel)
			2'(io_ports_pkg::OPEN_DRAIN_IDX): pick_port = src[io_ports_pkg::OPEN_DRAIN_IDX];
			2'(io_ports_pkg::PORT_ONE_IDX): pick_port = src[io_ports_pkg::PORT_ONE_IDX];
			2'(io_ports_pkg::PORT_TWO_IDX): pick_port = src[io_ports_pkg::PORT_TWO_IDX];
			2'(io_ports_pkg::PORT_THREE_IDX): pick_port = src[io_ports_pkg::PORT_THREE_IDX];
		endcase
	endfunction : pick_port

	// Open-drain port under bus control: push-pull when sending, floating when receiving
	function automatic io_ports_pkg::pin_drive_s od_bus_drive(input io_ports_pkg::ext_bus_s bus);
		io_ports_pkg::pin_drive_s d;
		d.drive_low = '0;
		d.drive_high = '0;
		if (bus.ext_low_drive && !bus.ext_data_in) begin
			d.drive_low = ~bus.ext_low_out;
			d.drive_high = bus.ext_low_out;
		end
		od_bus_drive = d;
	endfunction : od_bus_drive

	////////////////////////////////////////////////////////////////////////////////
	// Pin inputs and bus ownership
	assign pin_raw[io_ports_pkg::OPEN_DRAIN_IDX] = open_drain_port_pin_i;
	assign pin_raw[io_ports_pkg::PORT_ONE_IDX] = port_one_pin_i;
	assign pin_raw[io_ports_pkg::PORT_TWO_IDX] = port_two_pin_i;
	assign pin_raw[io_ports_pkg::PORT_THREE_IDX] = port_three_pin_i;
	assign ext_bus_active = ext_bus_i.ext_bus_active && !external_access_select_i;

	////////////////////////////////////////////////////////////////////////////////
	// Per-port logic
	genvar gp;
	generate
		for (gp = 0; gp < io_ports_pkg::NUM_PORTS; gp++) begin : g_port
			pin_sync u_sync (
				.clk_i(clk_i),
				.rst_i(rst_i),
				.pin_i(pin_raw[gp]),
				.sync_o(pin_synced[gp])
			);

			// Latch: bus forcing beats a core write in the same cycle
			always_comb begin
				latch_next[gp] = latch_reg[gp];
				if (core_write_i.write_strobe[gp]) begin
					latch_next[gp] = core_write_i.write_data;
				end
				if (gp == io_ports_pkg::OPEN_DRAIN_IDX && ext_bus_active) begin
					latch_next[gp] = io_ports_pkg::ALL_ONES;
				end
			end

			always_ff @(posedge clk_i) begin
				if (rst_i) begin
					latch_reg[gp] <= io_ports_pkg::LATCH_RESET;
				end else begin
					latch_reg[gp] <= latch_next[gp];
				end
			end

			// Output stage copy once per machine cycle
			always_comb begin
				stage_next[gp] = stage_reg[gp];
				if (cycle_state_i == io_ports_pkg::STATE_TWELVE) begin
					stage_next[gp] = latch_reg[gp];
				end
			end

			always_ff @(posedge clk_i) begin
				if (rst_i) begin
					stage_reg[gp] <= io_ports_pkg::LATCH_RESET;
				end else begin
					stage_reg[gp] <= stage_next[gp];
				end
			end

			// Pin sample in the port's slot: STATE_NINE shared by ports 0 and 1, STATE_TEN by ports 2 and 3
			always_comb begin
				sample_next[gp] = sample_reg[gp];
				if (is_sample_state(gp, cycle_state_i)) begin
					sample_next[gp] = pin_synced[gp];
				end
			end

			always_ff @(posedge clk_i) begin
				if (rst_i) begin
					sample_reg[gp] <= io_ports_pkg::LATCH_RESET;
				end else begin
					sample_reg[gp] <= sample_next[gp];
				end
			end
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////////
	// Output stages
	always_comb begin
		// Weak pull-ups sit on the board; drive_high stays low except on the open-drain port while the bus sends
		for (int i = 0; i < io_ports_pkg::NUM_PORTS; i++) begin
			drive_next[i].drive_low = ~stage_reg[i];
			drive_next[i].drive_high = '0;
		end
		if (ext_bus_active) begin
			// Address/data bus replaces latch contents on the pins
			drive_next[io_ports_pkg::OPEN_DRAIN_IDX] = od_bus_drive(ext_bus_i);
			drive_next[io_ports_pkg::PORT_TWO_IDX].drive_low = ~ext_bus_i.ext_high_out;
		end
	end

	// Registered so each pin control comes straight from a flop
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			for (int i = 0; i < io_ports_pkg::NUM_PORTS; i++) begin
				drive_reg[i] <= '{drive_low: '0, drive_high: '0};
			end
		end else begin
			for (int i = 0; i < io_ports_pkg::NUM_PORTS; i++) begin
				drive_reg[i] <= drive_next[i];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Read paths
	// Register reads return the latch, never the pin level
	always_comb begin
		latch_read_next = pick_port(latch_reg, read_port_sel_i);
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			latch_read_reg <= io_ports_pkg::LATCH_RESET;
		end else begin
			latch_read_reg <= latch_read_next;
		end
	end

	always_comb begin
		pin_read_next = pick_port(sample_reg, read_port_sel_i);
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pin_read_reg <= io_ports_pkg::LATCH_RESET;
		end else begin
			pin_read_reg <= pin_read_next;
		end
	end

	assign latch_read_o = latch_read_reg;
	assign pin_read_o = pin_read_reg;
	assign open_drain_port_o = drive_reg[io_ports_pkg::OPEN_DRAIN_IDX];
	assign port_one_o = drive_reg[io_ports_pkg::PORT_ONE_IDX];
	assign port_two_o = drive_reg[io_ports_pkg::PORT_TWO_IDX];
	assign port_three_o = drive_reg[io_ports_pkg::PORT_THREE_IDX];
endmodule : io_ports

// file: rtl/io_ports_pkg.sv
// Shared constants and carrier types for the four I/O ports
package io_ports_pkg;
	localparam int PORT_W = 8;
	localparam int NUM_PORTS = 4;
	localparam logic [7:0] LATCH_RESET = 8'hFF;
	localparam logic [7:0] ALL_ONES = 8'hFF;
	localparam int OPEN_DRAIN_IDX = 0;
	localparam int PORT_ONE_IDX = 1;
	localparam int PORT_TWO_IDX = 2;
	localparam int PORT_THREE_IDX = 3;
	localparam logic [3:0] STATE_NINE = 4'h8;
	localparam logic [3:0] STATE_TEN = 4'h9;
	localparam logic [3:0] STATE_TWELVE = 4'hB;
	localparam logic [3:0] STATE_LAST = 4'hB;
	localparam logic [3:0] STATE_FIRST = 4'h0;

	typedef logic [PORT_W-1:0] byte_t;

	typedef struct packed {
		logic [NUM_PORTS-1:0] write_strobe;
		byte_t write_data;
	} core_write_s;

	typedef struct packed {
		logic ext_bus_active;
		logic ext_data_in;
		byte_t ext_low_out;
		logic ext_low_drive;
		byte_t ext_high_out;
	} ext_bus_s;

	typedef struct packed {
		byte_t drive_low;
		byte_t drive_high;
	} pin_drive_s;
endpackage : io_ports_pkg

// file: rtl/pin_sync.sv
// Two-stage synchroniser for one byte of pin levels
`timescale 1ns/10ps
module pin_sync (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire io_ports_pkg::byte_t pin_i,
	output io_ports_pkg::byte_t sync_o
);
	io_ports_pkg::byte_t meta_reg, meta_next;
	io_ports_pkg::byte_t sync_reg, sync_next;

	always_comb begin
		meta_next = pin_i;
		sync_next = meta_reg;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			meta_reg <= io_ports_pkg::LATCH_RESET;
			sync_reg <= io_ports_pkg::LATCH_RESET;
		end else begin
			meta_reg <= meta_next;
			sync_reg <= sync_next;
		end
	end

	assign sync_o = sync_reg;
endmodule : pin_sync

// file: dv/io_ports_props.sv
// Concurrent checks on the I/O port block
`timescale 1ns/10ps
module io_ports_props (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [3:0] cycle_state_i,
	input wire io_ports_pkg::core_write_s core_write_i,
	input wire logic [1:0] read_port_sel_i,
	input wire logic external_access_select_i,
	input wire io_ports_pkg::ext_bus_s ext_bus_i,
	input wire io_ports_pkg::byte_t latch_read_o,
	input wire io_ports_pkg::byte_t pin_read_o,
	input wire io_ports_pkg::pin_drive_s open_drain_port_o,
	input wire io_ports_pkg::pin_drive_s port_one_o,
	input wire io_ports_pkg::pin_drive_s port_two_o
);
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);
	wire logic ext = ext_bus_i.ext_bus_active & ~external_access_select_i;
	property p_reset;
		disable iff (1'b0) rst_i |=> latch_read_o == 8'hFF && port_one_o.drive_low == 8'h00;
	endproperty
	property p_write;
		core_write_i.write_strobe[1] && read_port_sel_i == 2'h1 ##1 read_port_sel_i == 2'h1
			|=> latch_read_o == $past(core_write_i.write_data, 2);
	endproperty
	property p_weak;
		port_one_o.drive_high == 8'h00 && port_two_o.drive_high == 8'h00;
	endproperty
	property p_pullup;
		open_drain_port_o.drive_high != 8'h00 |-> $past(ext);
	endproperty
	property p_stage;
		$changed(port_one_o.drive_low) |-> $past(cycle_state_i, 2) == 4'hB;
	endproperty
	property p_pinrd;
		$past(read_port_sel_i) == 2'h1 && $past(read_port_sel_i, 2) == 2'h1 && $changed(pin_read_o)
			|-> $past(cycle_state_i, 2) == 4'h8;
	endproperty
	property p_forced;
		ext && ext_bus_i.ext_data_in && read_port_sel_i == 2'h0 ##1 read_port_sel_i == 2'h0
			|=> latch_read_o == 8'hFF;
	endproperty
	property p_high;
		ext |=> port_two_o.drive_low == ~$past(ext_bus_i.ext_high_out);
	endproperty
	a_reset: assert property (p_reset) else $error("bad reset state");
	a_write: assert property (p_write) else $error("bad latch write");
	a_weak: assert property (p_weak) else $error("pull-up on port");
	a_pullup: assert property (p_pullup) else $error("pull-up outside bus");
	a_stage: assert property (p_stage) else $error("stage off slot");
	a_pinrd: assert property (p_pinrd) else $error("pin sample off slot");
	a_forced: assert property (p_forced) else $error("latch not forced");
	a_high: assert property (p_high) else $error("high byte wrong");
	c_write: cover property (core_write_i.write_strobe[1]);
	c_ext: cover property (ext && ext_bus_i.ext_data_in);
	c_pin: cover property ($changed(pin_read_o));
	c_push: cover property (open_drain_port_o.drive_high != 8'h00);
endmodule : io_ports_props
bind io_ports io_ports_props u_props (.*);

// file: dv/board_model.sv
// Board circuitry on one port: pull-up or floating lines, optional driver
`timescale 1ns/10ps
module board_model #(
	parameter bit PULL = 1'b1
) (
	input wire logic clk_i,
	input wire io_ports_pkg::pin_drive_s drv_i,
	input wire io_ports_pkg::byte_t en_i,
	input wire io_ports_pkg::byte_t val_i,
	output io_ports_pkg::byte_t pin_o
);
	io_ports_pkg::byte_t tog_reg = 8'h55;
	always @(posedge clk_i) tog_reg <= ~tog_reg;
	// Sink wins; undriven open-drain lines wander
	assign pin_o = ~drv_i.drive_low & (drv_i.drive_high | (en_i & val_i)
		| (~en_i & (PULL ? 8'hFF : tog_reg)));
endmodule : board_model

// file: dv/tb_io_ports.sv
// Self-checking bench for the I/O port block
`timescale 1ns/10ps
`define CMP(g, e) begin checked++; if ((g) !== (e)) begin n_mismatch++; \
	$display("unexpected at %0t got %h exp %h", $time, g, e); end end
module tb_io_ports;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic [3:0] st = 4'h0;
	io_ports_pkg::core_write_s cw = '0;
	logic [1:0] sel = 2'h0;
	logic eas = 1'b1;
	io_ports_pkg::ext_bus_s eb = '0;
	io_ports_pkg::byte_t en [4] = '{default: 8'h00};
	io_ports_pkg::byte_t val [4] = '{default: 8'h00};
	io_ports_pkg::byte_t pins [4];
	io_ports_pkg::pin_drive_s drv [4];
	io_ports_pkg::byte_t lr, pr, got, ex, h, lo;
	io_ports_pkg::byte_t q [$];
	logic take = 1'b0;
	int what = 0;
	int n_mismatch = 0;
	int checked = 0;
	always #12.5 clk_i = ~clk_i;
	always @(posedge clk_i) st <= #1 (st == 4'hB) ? 4'h0 : st + 4'h1;
	io_ports DUT (.clk_i(clk_i), .rst_i(rst_i), .cycle_state_i(st), .core_write_i(cw),
		.read_port_sel_i(sel), .external_access_select_i(eas), .ext_bus_i(eb),
		.open_drain_port_pin_i(pins[0]), .port_one_pin_i(pins[1]), .port_two_pin_i(pins[2]),
		.port_three_pin_i(pins[3]), .latch_read_o(lr), .pin_read_o(pr),
		.open_drain_port_o(drv[0]), .port_one_o(drv[1]), .port_two_o(drv[2]),
		.port_three_o(drv[3]));
	for (genvar i = 0; i < 4; i++) begin : g_brd
		board_model #(.PULL(i != 0)) u_brd (.clk_i(clk_i), .drv_i(drv[i]), .en_i(en[i]),
			.val_i(val[i]), .pin_o(pins[i]));
	end
	assign got = (what == 4) ? lr : (what == 5) ? pr
		: (what >= 6) ? drv[what - 6].drive_high : drv[what].drive_low;
	always @(posedge clk_i) if (take) begin
		ex = q.pop_front();
		`CMP(got, ex)
	end
	task chk(input int w, input io_ports_pkg::byte_t e);
		what = w;
		q.push_back(e);
		take = 1'b1;
		@(posedge clk_i) #1 take = 1'b0;
		@(posedge clk_i) #1;
	endtask : chk
	task wr(input int p, input io_ports_pkg::byte_t v);
		cw.write_strobe = 4'h1 << p;
		cw.write_data = v;
		sel = p[1:0];
		@(posedge clk_i) #1 cw.write_strobe = 4'h0;
		@(posedge clk_i) #1 chk(4, v);
	endtask : wr
	task test_done;
		$display("checked %0d mismatches %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask : test_done
	initial begin
		repeat (3000) @(posedge clk_i);
		n_mismatch++;
		test_done;
	end
	initial begin
		void'($urandom(12799));
		repeat (3) @(posedge clk_i);
		#1 rst_i = 1'b0;
		for (int p = 0; p < 4; p++) begin
			sel = p[1:0];
			@(posedge clk_i) #1 chk(4, 8'hFF);
		end
		$display("reset test done");
		for (int p = 0; p < 4; p++) begin
			h = 8'($urandom());
			wr(p, h);
			repeat (14) @(posedge clk_i);
			#1 chk(p, ~h);
		end
		$display("output test done");
		for (int p = 0; p < 4; p++) begin
			wr(p, 8'hFF);
			en[p] = 8'hFF;
			val[p] = 8'($urandom());
			repeat (45) @(posedge clk_i);
			#1 chk(5, val[p]);
			chk(4, 8'hFF);
			chk(p, 8'h00);
			chk(p + 6, 8'h00);
		end
		$display("input test done");
		wr(2, 8'hA5);
		wr(0, 8'h00);
		h = 8'($urandom());
		eas = 1'b0;
		eb.ext_bus_active = 1'b1;
		eb.ext_data_in = 1'b1;
		eb.ext_high_out = h;
		repeat (3) @(posedge clk_i);
		#1 chk(4, 8'hFF);
		chk(2, ~h);
		chk(0, 8'h00);
		chk(6, 8'h00);
		lo = 8'($urandom());
		sel = 2'h2;
		eb.ext_data_in = 1'b0;
		eb.ext_low_drive = 1'b1;
		eb.ext_low_out = lo;
		@(posedge clk_i) #1 chk(6, lo);
		chk(0, ~lo);
		chk(4, 8'hA5);
		eas = 1'b1;
		@(posedge clk_i) #1 chk(6, 8'h00);
		repeat (14) @(posedge clk_i);
		#1 chk(0, 8'h00);
		chk(2, 8'h5A);
		$display("bus test done");
		rst_i = 1'b1;
		repeat (3) @(posedge clk_i);
		#1 rst_i = 1'b0;
		@(posedge clk_i) #1 chk(4, 8'hFF);
		chk(2, 8'h00);
		$display("reset again test done");
		test_done;
	end
endmodule : tb_io_ports
